//--- design/rld_pkg.sv
// Package for the return-with-literal decode block
package rld_pkg;

    // ==================================================
    // Widths
    localparam int OPCODE_W = 14;
    localparam int DATA_W   = 8;
    localparam int PC_W     = 13;

    // ==================================================
    // Opcode pattern: 11 01xx kkkk kkkk
    localparam logic [3:0] RETURN_WITH_LITERAL_OP_MATCH_VAL = 4'hD;
    localparam int         MATCH_HI        = 13;
    localparam int         MATCH_LO        = 10;
    localparam int         LIT_HI          = 7;
    localparam int         LIT_LO          = 0;

    // ==================================================
    // Reset values and timing
    localparam logic [DATA_W-1:0] ACC_RST     = 8'h00;
    localparam logic [PC_W-1:0]   PC_RST      = 13'h0000;
    localparam int                EXEC_CYCLES = 2;
    localparam int                INSTR_WORDS = 1;

    // Quarter phases of the instruction cycle
    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} rld_phase_t;

    // Decoded opcode fields
    typedef struct packed {
        logic              match;
        logic [DATA_W-1:0] literal;
    } rld_decode_t;

    // Core state updates
    typedef struct packed {
        logic              acc_we;
        logic [DATA_W-1:0] acc_data;
        logic              pc_we;
        logic [PC_W-1:0]   pc_data;
        logic              pop;
        logic              flags_we;
    } rld_update_t;

endpackage

//--- design/rld_opcode_match.sv
// Opcode matcher for return-with-literal
`timescale 1ns/10ps
module rld_opcode_match
(
    input  wire logic [rld_pkg::OPCODE_W-1:0] opcode_in,
    output rld_pkg::rld_decode_t               decode_out
);

    // ==================================================
    // Decode
    always_comb
    begin
        decode_out.match   = (opcode_in[rld_pkg::MATCH_HI:rld_pkg::MATCH_LO] == rld_pkg::RETURN_WITH_LITERAL_OP_MATCH_VAL);
        decode_out.literal = opcode_in[rld_pkg::LIT_HI:rld_pkg::LIT_LO];
    end

endmodule

//--- design/rld_return_literal_decode.sv
// Return-with-literal execution unit of the core
// Notes on behaviour
// - 11 01xx opcode loads low byte into accumulator
// - Program counter takes popped stack top value
// - One word, two cycles, second cycle idle
// - Q1 decode, Q2 literal, Q3 idle, Q4 pop
`timescale 1ns/10ps
module rld_return_literal_decode
(
    input  wire logic                         core_clk_in,
    input  wire logic                         srst_in,
    input  wire logic                         instr_valid_in,
    input  wire logic [rld_pkg::OPCODE_W-1:0] opcode_in,
    input  wire logic [rld_pkg::PC_W-1:0]     stack_top_in,
    output logic [rld_pkg::DATA_W-1:0]        acc_out,
    output logic [rld_pkg::PC_W-1:0]          pc_out,
    output logic                              pc_load_out,
    output logic                              stack_pop_out,
    output logic                              flags_we_out,
    output logic                              busy_out,
    output logic [1:0]                        phase_out
);

    // ==================================================
    // Execution states of the two instruction cycles
    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_FIRST,
        ST_SECOND
    } rld_exec_t;

    // ==================================================
    // Internal signals
    rld_pkg::rld_decode_t       dec;
    rld_pkg::rld_update_t       upd;
    rld_pkg::rld_phase_t        phase_ff;
    rld_pkg::rld_phase_t        nxt_phase;
    rld_exec_t                  state_ff;
    rld_exec_t                  nxt_state;
    logic [1:0]                 cyc_ff;
    logic [1:0]                 nxt_cyc;
    logic                       take;
    logic                       last_quarter;
    logic [rld_pkg::DATA_W-1:0] lit_ff;
    logic [rld_pkg::DATA_W-1:0] acc_ff;
    logic [rld_pkg::PC_W-1:0]   pc_ff;
    logic                       pc_load_ff;
    logic                       pop_ff;
    logic                       flags_we_ff;

    // ==================================================
    // Quarter decode within the first cycle
    function automatic logic first_cycle_quarter
    (
        input rld_exec_t           state,
        input rld_pkg::rld_phase_t phase,
        input rld_pkg::rld_phase_t want
    );
        first_cycle_quarter = (state == ST_FIRST) && (phase == want);
    endfunction

    // ==================================================
    // Opcode match
    rld_opcode_match u_match
    (
        .opcode_in  (opcode_in),
        .decode_out (dec)
    );

    // ==================================================
    // Quarter phase counter, free running
    always_comb
    begin
        case (phase_ff)
            rld_pkg::Q1: nxt_phase = rld_pkg::Q2;
            rld_pkg::Q2: nxt_phase = rld_pkg::Q3;
            rld_pkg::Q3: nxt_phase = rld_pkg::Q4;
            default:     nxt_phase = rld_pkg::Q1;
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            phase_ff <= rld_pkg::Q1;
        end
        else
        begin
            phase_ff <= nxt_phase;
        end
    end

    // ==================================================
    // Instruction take, only at Q1 while idle
    assign last_quarter = (phase_ff == rld_pkg::Q4);
    assign take         = (phase_ff == rld_pkg::Q1) && (state_ff == ST_IDLE) && instr_valid_in && dec.match;

    // ==================================================
    // Two instruction cycles, second one idle
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cyc   = cyc_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (take)
                begin
                    nxt_state = ST_FIRST;
                    nxt_cyc   = 2'h0;
                end
            end
            ST_FIRST:
            begin
                if (last_quarter)
                begin
                    nxt_state = ST_SECOND;
                    nxt_cyc   = cyc_ff + 2'h1;
                end
            end
            default:
            begin
                // Busy until the last idle quarter ends
                if (last_quarter && (cyc_ff == 2'(rld_pkg::EXEC_CYCLES - 1)))
                begin
                    nxt_state = ST_IDLE;
                    nxt_cyc   = 2'h0;
                end
                else if (last_quarter)
                begin
                    nxt_cyc = cyc_ff + 2'h1;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            state_ff <= ST_IDLE;
            cyc_ff   <= 2'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            cyc_ff   <= nxt_cyc;
        end
    end

    // ==================================================
    // Literal captured at take, so the opcode may move on
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            lit_ff <= rld_pkg::ACC_RST;
        end
        else if (take)
        begin
            lit_ff <= dec.literal;
        end
    end

    // ==================================================
    // Core state updates by quarter
    always_comb
    begin
        upd.acc_we   = first_cycle_quarter(state_ff, phase_ff, rld_pkg::Q2);
        upd.acc_data = lit_ff;
        upd.pc_we    = first_cycle_quarter(state_ff, phase_ff, rld_pkg::Q4);
        upd.pc_data  = stack_top_in;
        upd.pop      = first_cycle_quarter(state_ff, phase_ff, rld_pkg::Q4);
        upd.flags_we = 1'h0;
    end

    // ==================================================
    // Accumulator
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            acc_ff <= rld_pkg::ACC_RST;
        end
        else if (upd.acc_we)
        begin
            acc_ff <= upd.acc_data;
        end
    end

    // ==================================================
    // Program counter from stack top
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            pc_ff <= rld_pkg::PC_RST;
        end
        else if (upd.pc_we)
        begin
            pc_ff <= upd.pc_data;
        end
    end

    // ==================================================
    // One-clock pulses for load and pop; flags write register held low
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            pc_load_ff  <= 1'h0;
            pop_ff      <= 1'h0;
            flags_we_ff <= 1'h0;
        end
        else
        begin
            pc_load_ff  <= upd.pc_we;
            pop_ff      <= upd.pop;
            flags_we_ff <= upd.flags_we;
        end
    end

    // ==================================================
    // Outputs
    assign acc_out       = acc_ff;
    assign pc_out        = pc_ff;
    assign pc_load_out   = pc_load_ff;
    assign stack_pop_out = pop_ff;
    assign flags_we_out  = flags_we_ff;
    assign busy_out      = (state_ff != ST_IDLE);
    assign phase_out     = phase_ff;

endmodule

//--- test/rld_asserts.sv
// Checker for the return-with-literal decode block
`timescale 1ns/10ps
module rld_asserts
(
    input wire logic        core_clk_in,
    input wire logic        srst_in,
    input wire logic        instr_valid_in,
    input wire logic [13:0] opcode_in,
    input wire logic [12:0] stack_top_in,
    input wire logic [7:0]  acc_out,
    input wire logic [12:0] pc_out,
    input wire logic        pc_load_out,
    input wire logic        stack_pop_out,
    input wire logic        flags_we_out,
    input wire logic        busy_out,
    input wire logic [1:0]  phase_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    // ==========
    // Take and pop
    sequence s_take;
        phase_out == 2'h0 && instr_valid_in && opcode_in[13:10] == 4'hD && !busy_out;
    endsequence
    sequence s_pop;
        !pc_load_out [*3] ##1 pc_load_out ##1 !pc_load_out;
    endsequence
    property p_lit;
        logic [7:0] k;
        (s_take, k = opcode_in[7:0]) |-> ##3 acc_out == k;
    endproperty
    AST_LIT: assert property (p_lit) else $error("literal not loaded");
    AST_Q4: assert property (s_take |=> s_pop) else $error("pop not in fourth quarter");
    AST_PC: assert property (s_take |-> ##4 pc_out == $past(stack_top_in)) else $error("pc not from stack");
    AST_TWO: assert property (s_take |=> busy_out [*7] ##1 !busy_out) else $error("not two cycles");
    AST_REFUSE: assert property (phase_out == 2'h0 && !busy_out && !(instr_valid_in && opcode_in[13:10] == 4'hD) |=> !busy_out) else $error("bad opcode taken");
    AST_HOLD: assert property (!busy_out |=> $stable(acc_out) && $stable(pc_out)) else $error("state moved");
    AST_FLAG: assert property (!flags_we_out) else $error("flags written");
    AST_PAIR: assert property (pc_load_out == stack_pop_out) else $error("pop without load");
endmodule
bind rld_return_literal_decode rld_asserts u_chk (.*);

//--- test/tb_top.sv
// Testbench for the return-with-literal decode block
`timescale 1ns/10ps
module tb_top;
    logic        core_clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        instr_valid_in = 1'b0;
    logic [13:0] opcode_in = 14'h0000;
    logic [12:0] stack_top_in = 13'h0000;
    logic [7:0]  acc_out, exp_acc = 8'h00;
    logic [12:0] pc_out, exp_pc = 13'h0000;
    logic        pc_load_out, stack_pop_out, flags_we_out, busy_out;
    logic [1:0]  phase_out;
    int          miscompares = 0;
    int          compares = 0;
    always #50 core_clk_in = ~core_clk_in;
    rld_return_literal_decode dut (.*);
    task stop_test;
        if (miscompares == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One instruction, optional clash while busy
    task op(input logic [13:0] opc, input logic [12:0] top, input logic hit, input logic clash);
        int i;
        i = 0;
        do @(posedge core_clk_in); while (phase_out !== 2'h3 && ++i < 8);
        opcode_in <= opc;
        stack_top_in <= top;
        instr_valid_in <= 1'b1;
        @(posedge core_clk_in);
        instr_valid_in <= 1'b0;
        if (hit) exp_pc = top;
        if (hit) exp_acc = opc[7:0];
        repeat (3) @(posedge core_clk_in);
        if (clash) opcode_in <= 14'h3455;
        instr_valid_in <= clash;
        #1;
        chk(pc_load_out, hit);
        chk(stack_pop_out, hit);
        chk(pc_out, exp_pc);
        chk(flags_we_out, 1'b0);
        chk(busy_out, hit);
        @(posedge core_clk_in);
        instr_valid_in <= 1'b0;
        i = 0;
        do @(posedge core_clk_in); while (busy_out !== 1'b0 && ++i < 16);
        chk(busy_out, 1'b0);
        chk(acc_out, exp_acc);
    endtask
    task t_literal;
        op(14'h34AB, 13'h1ABC, 1'b1, 1'b0);
        op(14'h375A, 13'h0001, 1'b1, 1'b0);
        op(14'h3600, 13'h1FFF, 1'b1, 1'b0);
        op(14'h35FF, 13'h0F0F, 1'b1, 1'b1);
    endtask
    task t_refuse;
        op(14'h3CAB, 13'h0123, 1'b0, 1'b0);
        op(14'h14AB, 13'h0456, 1'b0, 1'b0);
    endtask
    initial
    begin
        repeat (8) @(posedge core_clk_in);
        srst_in <= 1'b0;
        t_literal;
        t_refuse;
        stop_test;
    end
    initial
    begin
        #100000;
        miscompares++;
        stop_test;
    end
endmodule
